/* src/aam_defines.vh */
// Constants for the ARP access-control entry matcher
// Assumes byte addressing on a 32-bit Wishbone bus, one register per word
`ifndef AAM_DEFINES_VH
`define AAM_DEFINES_VH

// Register byte offsets
`define AAM_OFF_CTRL 8'h00
`define AAM_OFF_SIP_ADDR 8'h04
`define AAM_OFF_SIP_MASK 8'h08
`define AAM_OFF_TIP_ADDR 8'h0C
`define AAM_OFF_TIP_MASK 8'h10
`define AAM_OFF_STATUS 8'h14
`define AAM_OFF_HIT_CNT 8'h18
`define AAM_OFF_ARP_CNT 8'h1C

// Control register field positions
`define AAM_CTRL_FTYPE_LSB 0
`define AAM_CTRL_OPC_LSB 4
`define AAM_CTRL_RR_LSB 6
`define AAM_CTRL_SIP_LSB 8
`define AAM_CTRL_TIP_LSB 10
`define AAM_CTRL_SHA_LSB 12
`define AAM_CTRL_THA_LSB 14
`define AAM_CTRL_LEN_LSB 16
`define AAM_CTRL_HRD_LSB 18
`define AAM_CTRL_PRO_LSB 20
`define AAM_CTRL_MASK 32'h003F_FFF7

// Reset values
`define AAM_RST_CTRL 32'h0000_0000
`define AAM_RST_ADDR 32'h0000_0000
`define AAM_RST_MASK 32'hFFFF_FFFF

// Status register field positions
`define AAM_STAT_HIT_BIT 0
`define AAM_STAT_SEEN_BIT 1
`define AAM_STAT_PASS_LSB 16

// Entry frame type codes
`define AAM_FT_ANY 3'h0
`define AAM_FT_ETYPE 3'h1
`define AAM_FT_ARP 3'h2
`define AAM_FT_IPV4 3'h3
`define AAM_FT_IPV6 3'h4

// Frame kind codes from the parser
`define AAM_KIND_OTHER 2'h0
`define AAM_KIND_ARP 2'h1
`define AAM_KIND_IPV4 2'h2
`define AAM_KIND_IPV6 2'h3

// Operation-class settings
`define AAM_OPC_ANY 2'h0
`define AAM_OPC_ARP 2'h1
`define AAM_OPC_RARP 2'h2
`define AAM_OPC_OTHER 2'h3

// Request/reply settings
`define AAM_RR_REQUEST 2'h1
`define AAM_RR_REPLY 2'h2

// IP check modes
`define AAM_IP_HOST 2'h1
`define AAM_IP_NET 2'h2

// Three-valued check settings
`define AAM_TRI_ZERO 2'h1
`define AAM_TRI_ONE 2'h2

// Operation codes
`define AAM_OP_ARP_REQ 16'h0001
`define AAM_OP_ARP_REP 16'h0002
`define AAM_OP_RARP_REQ 16'h0003
`define AAM_OP_RARP_REP 16'h0004

// Field constants
`define AAM_HW_LEN_ETH 8'h06
`define AAM_PROTO_LEN_IP 8'h04
`define AAM_HW_SPACE_ETH 16'h0001
`define AAM_PROTO_SPACE_IP 16'h0800

`endif

/* src/aam_ip_check.v */
// Address match for one IP field of the entry: any, host or network
// Assumes mode and addresses are stable in the cycle they are used
`timescale 1ns/1ns
`default_nettype none
`include "aam_defines.vh"
module aam_ip_check #(
  parameter IP_W = 32
) (
  input wire [1:0] mode_i,
  input wire [IP_W-1:0] cfg_addr_i,
  input wire [IP_W-1:0] cfg_mask_i,
  input wire [IP_W-1:0] frame_addr_i,
  output reg pass_o
);

  wire [IP_W-1:0] diff;

  assign diff = cfg_addr_i ^ frame_addr_i;

  always @* begin
    case (mode_i)
      `AAM_IP_HOST: pass_o = ~(|diff);
      `AAM_IP_NET: pass_o = ~(|(diff & cfg_mask_i));
      default: pass_o = 1'b1;
    endcase
  end

endmodule // aam_ip_check
`default_nettype wire

/* src/aam_matcher.v */
// ARP/RARP field matcher for one access-control entry, with Wishbone registers
// Assumes a frame parser on clk_i giving one decoded frame per frm_valid_i pulse
// Notes on behaviour
// [R1] ARP checks apply only when entry frame type is ARP.
// [R2] ARP entry matches only frames the parser marked ARP or RARP.
// [R3] Operation class: any, ARP only, RARP only, or neither.
// [R4] Unknown class accepts only opcodes outside all ARP and RARP codes.
// [R5] Request/reply: any, requests only, or replies only.
// [R6] Sender IP host mode needs exact 32-bit equality; any ignores it.
// [R7] Sender IP network mode compares only where sender mask bits are one.
// [R8] Target IP uses same any, host and network modes on target address.
// [R9] Hardware comparisons use the frame's received Ethernet source MAC.
// [R10] Sender hardware check: 1 equal to source MAC, 0 different, any ignores.
// [R11] Target hardware check: 1 equal to source MAC, 0 different, any ignores.
// [R12] Length check 1 needs hardware length 0x06 and protocol length 0x04.
// [R13] Hardware space check 1 needs hardware space code equal to 1.
// [R14] Protocol space check 1 needs protocol space code equal to 0x800.
// [R15] Any setting of a three-valued check always passes.
// [R16] Setting 0 of length and space checks needs the field unequal.
// [R17] Hit only when frame type passes and, on ARP entries, every enabled check passes too.
`timescale 1ns/1ns
`default_nettype none
`include "aam_defines.vh"
module aam_matcher #(
  parameter MAC_W = 48,
  parameter IP_W = 32,
  parameter CNT_W = 32
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire frm_valid_i,
  input wire [1:0] frm_kind_i,
  input wire [15:0] frm_arp_command_field_i,
  input wire [MAC_W-1:0] frm_source_mac_i,
  input wire [MAC_W-1:0] frm_sender_hw_address_i,
  input wire [MAC_W-1:0] frm_target_hw_address_i,
  input wire [IP_W-1:0] frm_sender_ip_i,
  input wire [IP_W-1:0] frm_target_ip_i,
  input wire [7:0] frm_hw_addr_length_i,
  input wire [7:0] frm_proto_addr_length_i,
  input wire [15:0] frm_hw_addr_space_i,
  input wire [15:0] frm_protocol_space_code_i,
  output reg result_valid_o,
  output reg hit_o,
  output reg miss_o
);

  localparam NCHK = 10;

  // Configuration and status registers
  reg [31:0] ctrl_r;
  reg [IP_W-1:0] sip_addr_r;
  reg [IP_W-1:0] sip_mask_r;
  reg [IP_W-1:0] tip_addr_r;
  reg [IP_W-1:0] tip_mask_r;
  reg last_hit_r;
  reg seen_r;
  reg [NCHK-1:0] pass_r;
  wire [CNT_W-1:0] hit_cnt;
  wire [CNT_W-1:0] arp_cnt;

  // Bus decode
  wire bus_req;
  wire bus_wr;
  wire bus_rd;
  wire [31:0] wmask;
  reg [31:0] rd_nxt;
  wire [1:0] cnt_clr;
  wire [1:0] cnt_evt;
  genvar gi;
  genvar gc;

  // Control fields
  wire [2:0] ftype;
  wire [1:0] opc_mode;
  wire [1:0] rr_mode;
  wire [1:0] sip_mode;
  wire [1:0] tip_mode;
  wire [1:0] sha_mode;
  wire [1:0] tha_mode;
  wire [1:0] len_mode;
  wire [1:0] hrd_mode;
  wire [1:0] pro_mode;

  // Opcode decode
  wire op_is_arp;
  wire op_is_rarp;
  wire op_is_req;
  wire op_is_rep;

  // Per-check results
  reg type_ok;
  reg opc_ok;
  reg rr_ok;
  wire sip_ok;
  wire tip_ok;
  wire sha_ok;
  wire tha_ok;
  wire len_ok;
  wire hrd_ok;
  wire pro_ok;
  wire arp_all_ok;
  wire [NCHK-1:0] pass_nxt;
  wire hit_nxt;
  wire arp_frame;

  // Three-valued check: any passes, setting 0 wants inequality, setting 1 equality
  function tri_ok;
    input [1:0] mode;
    input eq;
    begin
      case (mode)
        `AAM_TRI_ZERO: tri_ok = ~eq;
        `AAM_TRI_ONE: tri_ok = eq;
        default: tri_ok = 1'b1;
      endcase
    end
  endfunction

  // Field extraction from control
  assign ftype = ctrl_r[`AAM_CTRL_FTYPE_LSB +: 3];
  assign opc_mode = ctrl_r[`AAM_CTRL_OPC_LSB +: 2];
  assign rr_mode = ctrl_r[`AAM_CTRL_RR_LSB +: 2];
  assign sip_mode = ctrl_r[`AAM_CTRL_SIP_LSB +: 2];
  assign tip_mode = ctrl_r[`AAM_CTRL_TIP_LSB +: 2];
  assign sha_mode = ctrl_r[`AAM_CTRL_SHA_LSB +: 2];
  assign tha_mode = ctrl_r[`AAM_CTRL_THA_LSB +: 2];
  assign len_mode = ctrl_r[`AAM_CTRL_LEN_LSB +: 2];
  assign hrd_mode = ctrl_r[`AAM_CTRL_HRD_LSB +: 2];
  assign pro_mode = ctrl_r[`AAM_CTRL_PRO_LSB +: 2];

  // Opcode classes
  assign op_is_arp = (frm_arp_command_field_i == `AAM_OP_ARP_REQ) ||
                     (frm_arp_command_field_i == `AAM_OP_ARP_REP);
  assign op_is_rarp = (frm_arp_command_field_i == `AAM_OP_RARP_REQ) ||
                      (frm_arp_command_field_i == `AAM_OP_RARP_REP);
  assign op_is_req = (frm_arp_command_field_i == `AAM_OP_ARP_REQ) ||
                     (frm_arp_command_field_i == `AAM_OP_RARP_REQ);
  assign op_is_rep = (frm_arp_command_field_i == `AAM_OP_ARP_REP) ||
                     (frm_arp_command_field_i == `AAM_OP_RARP_REP);

  // [R2] Frame type condition
  always @* begin
    case (ftype)
      `AAM_FT_ANY: type_ok = 1'b1;
      `AAM_FT_ETYPE: type_ok = (frm_kind_i == `AAM_KIND_OTHER);
      `AAM_FT_ARP: type_ok = (frm_kind_i == `AAM_KIND_ARP);
      `AAM_FT_IPV4: type_ok = (frm_kind_i == `AAM_KIND_IPV4);
      `AAM_FT_IPV6: type_ok = (frm_kind_i == `AAM_KIND_IPV6);
      default: type_ok = 1'b0;
    endcase
  end

  // [R3] Operation class
  always @* begin
    case (opc_mode)
      `AAM_OPC_ARP: opc_ok = op_is_arp;
      `AAM_OPC_RARP: opc_ok = op_is_rarp;
      // [R4] Unknown opcode only
      `AAM_OPC_OTHER: opc_ok = ~op_is_arp & ~op_is_rarp;
      default: opc_ok = 1'b1;
    endcase
  end

  // [R5] Request or reply
  always @* begin
    case (rr_mode)
      `AAM_RR_REQUEST: rr_ok = op_is_req;
      `AAM_RR_REPLY: rr_ok = op_is_rep;
      default: rr_ok = 1'b1;
    endcase
  end

  // [R6] [R7] Sender address match
  aam_ip_check #(
    .IP_W(IP_W)
  ) u_sender_ip (
    .mode_i(sip_mode),
    .cfg_addr_i(sip_addr_r),
    .cfg_mask_i(sip_mask_r),
    .frame_addr_i(frm_sender_ip_i),
    .pass_o(sip_ok)
  );

  // [R8] Target address match
  aam_ip_check #(
    .IP_W(IP_W)
  ) u_target_ip (
    .mode_i(tip_mode),
    .cfg_addr_i(tip_addr_r),
    .cfg_mask_i(tip_mask_r),
    .frame_addr_i(frm_target_ip_i),
    .pass_o(tip_ok)
  );

  // [R9] [R10] Sender hardware address against source MAC
  assign sha_ok = tri_ok(sha_mode, frm_sender_hw_address_i == frm_source_mac_i);
  // [R11] Target hardware address against source MAC
  assign tha_ok = tri_ok(tha_mode, frm_target_hw_address_i == frm_source_mac_i);
  // [R12] [R16] Address lengths
  assign len_ok = tri_ok(len_mode, (frm_hw_addr_length_i == `AAM_HW_LEN_ETH) &&
                                   (frm_proto_addr_length_i == `AAM_PROTO_LEN_IP));
  // [R13] [R15] Hardware space code
  assign hrd_ok = tri_ok(hrd_mode, frm_hw_addr_space_i == `AAM_HW_SPACE_ETH);
  // [R14] Protocol space code
  assign pro_ok = tri_ok(pro_mode, frm_protocol_space_code_i == `AAM_PROTO_SPACE_IP);

  // Combined checks and per-check status vector
  assign arp_all_ok = opc_ok & rr_ok & sip_ok & tip_ok & sha_ok &
                      tha_ok & len_ok & hrd_ok & pro_ok;
  assign pass_nxt = {pro_ok, hrd_ok, len_ok, tha_ok, sha_ok,
                     tip_ok, sip_ok, rr_ok, opc_ok, type_ok};
  // Frames the parser marked ARP or RARP
  assign arp_frame = frm_valid_i & (frm_kind_i == `AAM_KIND_ARP);

  // [R1] [R17] ARP checks count only for ARP entries
  assign hit_nxt = type_ok & ((ftype != `AAM_FT_ARP) | arp_all_ok);

  // Result outputs, one cycle after the frame
  always @(posedge clk_i) begin
    if (rst_i) begin
      result_valid_o <= 1'b0;
      hit_o <= 1'b0;
      miss_o <= 1'b0;
      last_hit_r <= 1'b0;
      seen_r <= 1'b0;
      pass_r <= {NCHK{1'b0}};
    end else begin
      result_valid_o <= frm_valid_i;
      // [R17] Hit or miss per frame
      hit_o <= frm_valid_i & hit_nxt;
      miss_o <= frm_valid_i & ~hit_nxt;
      if (frm_valid_i) begin
        last_hit_r <= hit_nxt;
        seen_r <= 1'b1;
        pass_r <= pass_nxt;
      end
    end
  end

  // Wishbone classic slave
  // A take needs ack low, so each request is taken once
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr = bus_req & wb_we_i;
  assign bus_rd = bus_req & ~wb_we_i;
  // Byte lane write mask
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
      assign wmask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
    end
  endgenerate

  // Read data select
  always @* begin
    rd_nxt = 32'h0000_0000;
    case ({wb_adr_i[7:2], 2'b00})
      `AAM_OFF_CTRL: rd_nxt = ctrl_r & `AAM_CTRL_MASK;
      `AAM_OFF_SIP_ADDR: rd_nxt = sip_addr_r;
      `AAM_OFF_SIP_MASK: rd_nxt = sip_mask_r;
      `AAM_OFF_TIP_ADDR: rd_nxt = tip_addr_r;
      `AAM_OFF_TIP_MASK: rd_nxt = tip_mask_r;
      // [R17] Last verdict and per-check pass
      `AAM_OFF_STATUS: begin
        rd_nxt[`AAM_STAT_HIT_BIT] = last_hit_r;
        rd_nxt[`AAM_STAT_SEEN_BIT] = seen_r;
        rd_nxt[`AAM_STAT_PASS_LSB +: NCHK] = pass_r;
      end
      `AAM_OFF_HIT_CNT: rd_nxt = hit_cnt;
      `AAM_OFF_ARP_CNT: rd_nxt = arp_cnt;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // Registered ack and read data
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_rd) begin
        wb_dat_o <= rd_nxt;
      end
    end
  end

  // Configuration writes, honouring byte selects
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `AAM_RST_CTRL;
      sip_addr_r <= `AAM_RST_ADDR;
      sip_mask_r <= `AAM_RST_MASK;
      tip_addr_r <= `AAM_RST_ADDR;
      tip_mask_r <= `AAM_RST_MASK;
    end else if (bus_wr) begin
      case ({wb_adr_i[7:2], 2'b00})
        `AAM_OFF_CTRL: ctrl_r <= ((ctrl_r & ~wmask) | (wb_dat_i & wmask)) & `AAM_CTRL_MASK;
        `AAM_OFF_SIP_ADDR: sip_addr_r <= (sip_addr_r & ~wmask) | (wb_dat_i & wmask);
        `AAM_OFF_SIP_MASK: sip_mask_r <= (sip_mask_r & ~wmask) | (wb_dat_i & wmask);
        `AAM_OFF_TIP_ADDR: tip_addr_r <= (tip_addr_r & ~wmask) | (wb_dat_i & wmask);
        `AAM_OFF_TIP_MASK: tip_mask_r <= (tip_mask_r & ~wmask) | (wb_dat_i & wmask);
        // Unmapped writes are ignored
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  // Counters: a write clears, a same-cycle event still counts
  // Index 0 counts hits, index 1 counts ARP-kind frames
  assign cnt_clr[0] = bus_wr && ({wb_adr_i[7:2], 2'b00} == `AAM_OFF_HIT_CNT);
  assign cnt_clr[1] = bus_wr && ({wb_adr_i[7:2], 2'b00} == `AAM_OFF_ARP_CNT);
  assign cnt_evt[0] = frm_valid_i & hit_nxt;
  assign cnt_evt[1] = arp_frame;

  generate
    for (gc = 0; gc < 2; gc = gc + 1) begin : g_cnt
      reg [CNT_W-1:0] cnt_r;
      always @(posedge clk_i) begin
        if (rst_i) begin
          cnt_r <= {CNT_W{1'b0}};
        end else if (cnt_clr[gc]) begin
          cnt_r <= {{(CNT_W-1){1'b0}}, cnt_evt[gc]};
        end else if (cnt_evt[gc]) begin
          cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  endgenerate

  assign hit_cnt = g_cnt[0].cnt_r;
  assign arp_cnt = g_cnt[1].cnt_r;

endmodule // aam_matcher
`default_nettype wire

/* verification/aam_frame_src.sv */
// Frame parser stand-in: one decoded frame per request
// Assumes the bench hands fields packed in its own field order
`timescale 1ns/1ns
`default_nettype none
module aam_frame_src (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic [273:0] fld_i,
  output logic frm_valid_o,
  output logic [273:0] frm_o
);
  initial frm_valid_o = 1'b0;
  initial frm_o = '0;
  // Fields flip between frames so stale values never look valid
  always @(posedge clk_i) begin
    frm_valid_o <= req_i;
    frm_o <= req_i ? fld_i : ~frm_o;
  end
endmodule // aam_frame_src
`default_nettype wire

/* verification/aam_matcher_checker.sv */
// Port checker for the ARP entry matcher
// Assumes binding onto aam_matcher, single clock domain
`timescale 1ns/1ns
`default_nettype none
module aam_matcher_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic frm_valid_i,
  input wire logic result_valid_o,
  input wire logic hit_o,
  input wire logic miss_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_answer;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_frame_judged: assert property (frm_valid_i |=> result_valid_o)
    else $error("frame not judged");
  a_no_extra_result: assert property (!frm_valid_i |=> !result_valid_o)
    else $error("result without frame");
  a_hit_xor_miss: assert property (result_valid_o |-> hit_o ^ miss_o)
    else $error("hit and miss clash");
  a_verdict_framed: assert property ((hit_o || miss_o) |-> result_valid_o)
    else $error("verdict outside result");
  a_ack_one_late: assert property (s_take |=> s_answer)
    else $error("ack not a one cycle pulse");
  a_ack_caused: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_reset_quiet: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> !wb_ack_o && !result_valid_o && !hit_o && !miss_o)
    else $error("outputs active after reset");
  c_hit: cover property (result_valid_o && hit_o);
endmodule // aam_matcher_checker
bind aam_matcher aam_matcher_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .frm_valid_i(frm_valid_i),
  .result_valid_o(result_valid_o), .hit_o(hit_o), .miss_o(miss_o));
`default_nettype wire

/* verification/aam_matcher_tb.sv */
// Bench for the ARP entry matcher with a reference model
// Assumes aam_frame_src as parser and a Wishbone master here
`timescale 1ns/1ns
`default_nettype none
`include "aam_defines.vh"
module aam_matcher_tb;
  typedef struct packed {
    logic [1:0] kind;
    logic [15:0] op;
    logic [47:0] frame_source_mac, sha, target_hw_address;
    logic [31:0] sender_ip, tip;
    logic [7:0] hl, pl;
    logic [15:0] hw_addr_space, protocol_space_code;
  } aam_frm_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, req = 1'b0;
  logic [3:0] sel = 4'hF;
  logic [9:0] last_pass = 10'h000;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, dat_o, ctl, sa, sm, ta, tm;
  logic ack, rv, hit, miss, fv, e, last_hit;
  aam_frm_t fld = '0;
  aam_frm_t frm;
  int bad_count = 0, samples_checked = 0, hits = 0, arps = 0;
  logic q[$];
  aam_frame_src u_src (.clk_i(clk_i), .req_i(req), .fld_i(fld), .frm_valid_o(fv), .frm_o(frm));
  aam_matcher u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .frm_valid_i(fv), .frm_kind_i(frm.kind), .frm_arp_command_field_i(frm.op),
    .frm_source_mac_i(frm.frame_source_mac), .frm_sender_hw_address_i(frm.sha),
    .frm_target_hw_address_i(frm.target_hw_address), .frm_sender_ip_i(frm.sender_ip), .frm_target_ip_i(frm.tip),
    .frm_hw_addr_length_i(frm.hl), .frm_proto_addr_length_i(frm.pl),
    .frm_hw_addr_space_i(frm.hw_addr_space), .frm_protocol_space_code_i(frm.protocol_space_code),
    .result_valid_o(rv), .hit_o(hit), .miss_o(miss));
  initial forever #4 clk_i = ~clk_i;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      bad_count++;
      stop_test();
    end
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  function automatic logic ipm(logic [1:0] m, logic [31:0] a, k, x);
    return m == 2'h1 ? x == a : m == 2'h2 ? ((x ^ a) & k) == 32'h0000_0000 : 1'b1;
  endfunction
  function automatic logic trm(logic [1:0] s, logic eq);
    return s == 2'h1 ? !eq : s == 2'h2 ? eq : 1'b1;
  endfunction
  function automatic logic [9:0] exp_pass(aam_frm_t f);
    logic ia, ir, t, o, r;
    ia = f.op == 16'h0001 || f.op == 16'h0002;
    ir = f.op == 16'h0003 || f.op == 16'h0004;
    t = ctl[2:0] == 3'h0 || (ctl[2:0] < 3'h5 && ctl[2:0] != 3'h0 && f.kind == 2'(ctl[2:0] - 3'h1));
    o = ctl[5:4] == 2'h0 || (ctl[5:4] == 2'h1 ? ia : ctl[5:4] == 2'h2 ? ir : !ia && !ir);
    r = ctl[7:6] == 2'h1 ? f.op == 16'h0001 || f.op == 16'h0003 :
        ctl[7:6] == 2'h2 ? f.op == 16'h0002 || f.op == 16'h0004 : 1'b1;
    return {trm(ctl[21:20], f.protocol_space_code == 16'h0800), trm(ctl[19:18], f.hw_addr_space == 16'h0001),
            trm(ctl[17:16], f.hl == 8'h06 && f.pl == 8'h04), trm(ctl[15:14], f.target_hw_address == f.frame_source_mac),
            trm(ctl[13:12], f.sha == f.frame_source_mac), ipm(ctl[11:10], ta, tm, f.tip),
            ipm(ctl[9:8], sa, sm, f.sender_ip), r, o, t};
  endfunction
  function automatic logic exp_hit(logic [9:0] v);
    // ARP checks count only for ARP entries
    return v[0] && (ctl[2:0] != 3'h2 || &v[9:1]);
  endfunction
  task automatic send();
    aam_frm_t f;
    logic h;
    f.kind = ($urandom % 4 == 0) ? 2'($urandom) : 2'h1;
    f.op = 16'($urandom % 6);
    f.frame_source_mac = {16'($urandom), $urandom};
    f.sha = ($urandom % 2) ? f.frame_source_mac : {16'($urandom), $urandom};
    f.target_hw_address = ($urandom % 2) ? f.frame_source_mac : {16'($urandom), $urandom};
    f.sender_ip = ($urandom % 3 == 0) ? sa : ($urandom % 2) ? sa ^ ($urandom & ~sm) : $urandom;
    f.tip = ($urandom % 3 == 0) ? ta : ($urandom % 2) ? ta ^ ($urandom & ~tm) : $urandom;
    f.hl = ($urandom % 2) ? 8'h06 : 8'($urandom);
    f.pl = ($urandom % 2) ? 8'h04 : 8'($urandom);
    f.hw_addr_space = ($urandom % 2) ? 16'h0001 : 16'($urandom);
    f.protocol_space_code = ($urandom % 2) ? 16'h0800 : 16'($urandom);
    last_pass = exp_pass(f);
    h = exp_hit(last_pass);
    q.push_back(h);
    hits += h;
    arps += f.kind == 2'h1;
    last_hit = h;
    req <= 1'b1;
    fld <= f;
    @(posedge clk_i);
  endtask
  always @(negedge clk_i) begin
    if (rv === 1'b1) begin
      e = q.pop_front();
      chk("hit", 32'(hit), 32'(e));
      chk("miss", 32'(miss), 32'(!e));
    end
  end
  initial begin
    void'($urandom(36100));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, 8'h00, 32'h0000_0000);
    chk("ctrl reset", rdat, 32'h0000_0000);
    wb(1'b0, 8'h08, 32'h0000_0000);
    chk("mask reset", rdat, 32'hFFFF_FFFF);
    wb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped", rdat, 32'h0000_0000);
    sel <= 4'h5;
    wb(1'b1, 8'h0C, 32'hAABB_CCDD);
    sel <= 4'hF;
    wb(1'b0, 8'h0C, 32'h0000_0000);
    chk("byte select", rdat, 32'h00BB_00DD);
    for (int i = 0; i < 150; i++) begin
      ctl = $urandom;
      if ($urandom % 3) ctl[2:0] = 3'h2;
      sa = $urandom;
      ta = $urandom;
      sm = ~(32'hFFFF_FFFF >> ($urandom % 33));
      tm = ~(32'hFFFF_FFFF >> ($urandom % 33));
      wb(1'b1, 8'h00, ctl);
      wb(1'b1, 8'h04, sa);
      wb(1'b1, 8'h08, sm);
      wb(1'b1, 8'h0C, ta);
      wb(1'b1, 8'h10, tm);
      wb(1'b0, 8'h00, 32'h0000_0000);
      chk("ctrl", rdat, ctl & 32'h003F_FFF7);
      repeat (8) send();
      req <= 1'b0;
      repeat (3) @(posedge clk_i);
      wb(1'b0, 8'h14, 32'h0000_0000);
      chk("status", rdat & 32'h0000_0003, {30'h0, 1'b1, last_hit});
      chk("pass bits", (rdat >> 16) & 32'h0000_03FF, 32'(last_pass));
      wb(1'b0, 8'h18, 32'h0000_0000);
      chk("hit count", rdat, 32'(hits));
      wb(1'b0, 8'h1C, 32'h0000_0000);
      chk("arp count", rdat, 32'(arps));
      wb(1'b1, 8'h18, 32'h0000_0000);
      wb(1'b1, 8'h1C, 32'h0000_0000);
      hits = 0;
      arps = 0;
    end
    stop_test();
  end
endmodule // aam_matcher_tb
`default_nettype wire
